// ===== core/psar_pkg.sv
// constants for the phy status and negotiation register bank
package psar_pkg;
   // ---------------------------------------------------------------
   // register indexes
   // ---------------------------------------------------------------
   localparam logic [4:0] IDX_STATUS    = 5'h01;
   localparam logic [4:0] IDX_ID_HIGH   = 5'h02;
   localparam logic [4:0] IDX_ID_LOW    = 5'h03;
   localparam logic [4:0] IDX_ADVERTISE = 5'h04;
   localparam logic [4:0] IDX_PARTNER   = 5'h05;
   // ---------------------------------------------------------------
   // status word fixed bits and bit positions
   // ---------------------------------------------------------------
   localparam logic [4:0] STATUS_CAPS   = 5'h0F; // bits 15..11
   localparam int         ST_DONE_BIT   = 5;
   localparam int         ST_RFLT_BIT   = 4;
   localparam int         ST_ANCAP_BIT  = 3;
   localparam int         ST_LINK_BIT   = 2;
   localparam int         ST_JAB_BIT    = 1;
   localparam int         ST_EXT_BIT    = 0;
   // ---------------------------------------------------------------
   // identifier contents (arbitrary values, not any real part)
   // ---------------------------------------------------------------
   localparam logic [15:0] ORG_ID_HIGH  = 16'h1234; // arbitrary
   localparam logic [5:0]  ORG_ID_LOW   = 6'h15;    // arbitrary
   localparam logic [5:0]  MODEL_NUM    = 6'h2A;    // arbitrary
   localparam logic [3:0]  REVISION_NUM = 4'h3;     // arbitrary
   // ---------------------------------------------------------------
   // advertisement layout and reset values
   // ---------------------------------------------------------------
   localparam int         ADV_RFLT_BIT  = 13;
   localparam int         PAUSE_LSB     = 10;
   localparam int         TECH_LSB      = 5;
   localparam logic [1:0] PAUSE_NONE    = 2'h0;
   localparam logic [1:0] PAUSE_SYM     = 2'h1;
   localparam logic [1:0] PAUSE_ASYM    = 2'h2;
   localparam logic [1:0] PAUSE_BOTH    = 2'h3;
   localparam logic [3:0] ADV_TECH_RST  = 4'hF;
   localparam logic [4:0] SELECTOR_8023 = 5'h01;
   localparam logic [15:0] ADV_WR_MASK  = 16'h2DFF; // 13,11:10,8:0
   localparam logic [15:0] ADV_RST      = 16'h01E1;
   localparam logic [15:0] PARTNER_MASK = 16'h2FFF; // 13,11:0
endpackage : psar_pkg

// ===== core/psar_latch_bit.sv
// latching status bit: holds an event until read, then follows state
`timescale 1ns/10ps
`default_nettype none
module psar_latch_bit #(
   parameter bit LATCH_HIGH = 1'b1
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // condition and read release
   input  wire logic cond,
   input  wire logic rd_release,
   // latched view
   output var  logic value
);
   logic held;
   // an event in the release cycle still wins: set beats clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         held <= 1'b0;
      end else if (cond == LATCH_HIGH) begin
         held <= 1'b1;
      end else if (rd_release) begin
         held <= 1'b0;
      end
   end
   // latch high shows event or condition, latch low shows neither loss
   assign value = LATCH_HIGH ? (held | cond) : (~held & cond);
endmodule : psar_latch_bit
`default_nettype wire

// ===== core/psar_regs.sv
// phy status, identifier and negotiation register bank
`timescale 1ns/10ps
`default_nettype none
module psar_regs (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // management access port from the mac side
   input  wire logic        mgmt_req,
   input  wire logic        mgmt_write,
   input  wire logic [4:0]  mgmt_index,
   input  wire logic [15:0] mgmt_wdata,
   output var  logic [15:0] mgmt_rdata,
   output var  logic        mgmt_ack,
   // line side conditions (asynchronous)
   input  wire logic        link_up,
   input  wire logic        remote_fault,
   input  wire logic        jabber,
   // negotiation engine (same clock)
   input  wire logic        neg_done,
   input  wire logic        partner_load,
   input  wire logic [15:0] partner_word,
   // negotiated result
   output var  logic        pause_sym_en,
   output var  logic        pause_asym_en
);
   // ---------------------------------------------------------------
   // synchronisers for line conditions
   // ---------------------------------------------------------------
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else begin
         sync_a <= {link_up, remote_fault, jabber};
         sync_b <= sync_a;
      end
   end
   wire link_s  = sync_b[2];
   wire fault_s = sync_b[1];
   wire jab_s   = sync_b[0];

   // ---------------------------------------------------------------
   // access decode
   // ---------------------------------------------------------------
   wire rd_any    = mgmt_req & ~mgmt_write;
   wire rd_status = rd_any & (mgmt_index == psar_pkg::IDX_STATUS);
   wire wr_adv    = mgmt_req & mgmt_write
                  & (mgmt_index == psar_pkg::IDX_ADVERTISE);

   // latching bits, one instance per kind
   logic fault_v;
   logic link_v;
   logic jab_v;
   psar_latch_bit #(.LATCH_HIGH(1'b1)) u_fault (
      .clock      (clock),
      .rst_n      (rst_n),
      .cond       (fault_s),
      .rd_release (rd_status),
      .value      (fault_v)
   );
   psar_latch_bit #(.LATCH_HIGH(1'b0)) u_link (
      .clock      (clock),
      .rst_n      (rst_n),
      .cond       (link_s),
      .rd_release (rd_status),
      .value      (link_v)
   );
   psar_latch_bit #(.LATCH_HIGH(1'b1)) u_jab (
      .clock      (clock),
      .rst_n      (rst_n),
      .cond       (jab_s),
      .rd_release (rd_status),
      .value      (jab_v)
   );

   // ---------------------------------------------------------------
   // advertisement and partner storage
   // ---------------------------------------------------------------
   logic [15:0] adv;
   logic [15:0] partner;
   // only writable fields take write data; reserved bits stay zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         adv <= psar_pkg::ADV_RST;
      end else if (wr_adv) begin
         adv <= mgmt_wdata & psar_pkg::ADV_WR_MASK;
      end
   end
   // next page and acknowledge never captured; reserved 12 dropped
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         partner <= 16'h0000;
      end else if (partner_load) begin
         partner <= partner_word
                  & psar_pkg::PARTNER_MASK;
      end
   end

   // ---------------------------------------------------------------
   // pause resolution at completion
   // ---------------------------------------------------------------
   wire [1:0] adv_p  = adv[psar_pkg::PAUSE_LSB +: 2];
   wire [1:0] part_p = partner[psar_pkg::PAUSE_LSB +: 2];
   // symmetric preferred; asymmetric only when symmetric impossible
   wire sym_ok  = adv_p[0] & part_p[0];
   wire asym_ok = ~sym_ok & adv_p[1] & part_p[1];
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pause_sym_en  <= 1'b0;
         pause_asym_en <= 1'b0;
      end else begin
         pause_sym_en  <= neg_done & sym_ok;
         pause_asym_en <= neg_done & asym_ok;
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   wire [15:0] status_word = {
      psar_pkg::STATUS_CAPS,
      5'h00,
      neg_done,
      fault_v,
      1'b1,
      link_v,
      jab_v,
      1'b1};
   wire [15:0] id_low_word = {psar_pkg::ORG_ID_LOW,
      psar_pkg::MODEL_NUM, psar_pkg::REVISION_NUM};
   logic [15:0] next_rdata;
   always_comb begin
      case (mgmt_index)
         psar_pkg::IDX_STATUS:    next_rdata = status_word;
         psar_pkg::IDX_ID_HIGH:   next_rdata = psar_pkg::ORG_ID_HIGH;
         psar_pkg::IDX_ID_LOW:    next_rdata = id_low_word;
         psar_pkg::IDX_ADVERTISE: next_rdata = adv;
         psar_pkg::IDX_PARTNER:   next_rdata = partner;
         default:                 next_rdata = 16'h0000;
      endcase
   end
   // data registered with the ack, one cycle after the request
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mgmt_rdata <= 16'h0000;
         mgmt_ack   <= 1'b0;
      end else begin
         mgmt_ack <= mgmt_req;
         if (rd_any) begin
            mgmt_rdata <= next_rdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_caps;
      @(posedge clock) disable iff (!rst_n)
      rd_status |=> (mgmt_rdata[15:11] == psar_pkg::STATUS_CAPS)
         && (mgmt_rdata[10:6] == 5'h00);
   endproperty
   a_caps: assert property (p_caps) else $error("status caps wrong");
   property p_done;
      @(posedge clock) disable iff (!rst_n)
      rd_status |=> mgmt_rdata[psar_pkg::ST_DONE_BIT] == $past(neg_done);
   endproperty
   a_done: assert property (p_done) else $error("done bit wrong");
   property p_fault_hold;
      @(posedge clock) disable iff (!rst_n)
      (fault_s && !rd_status) ##1 !rd_status |=> fault_v;
   endproperty
   a_fault_hold: assert property (p_fault_hold)
      else $error("fault not held");
   property p_link_low;
      @(posedge clock) disable iff (!rst_n)
      (!link_s && !rd_status) |=> !link_v;
   endproperty
   a_link_low: assert property (p_link_low)
      else $error("link loss not held");
   property p_jab_hold;
      @(posedge clock) disable iff (!rst_n)
      (jab_s && !rd_status) |=> jab_v;
   endproperty
   a_jab_hold: assert property (p_jab_hold)
      else $error("jabber not held");
   // two reset edges so the time-zero race cannot leave a stale value
   property p_latch_reset;
      @(posedge clock)
      !rst_n ##1 !rst_n |-> !fault_v && !link_v && !jab_v;
   endproperty
   a_latch_reset: assert property (p_latch_reset)
      else $error("latched bit set in reset");
   property p_fixed;
      @(posedge clock) disable iff (!rst_n)
      rd_status |=> mgmt_rdata[3] && mgmt_rdata[0];
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed ones wrong");
   property p_id_high;
      @(posedge clock) disable iff (!rst_n)
      rd_any && (mgmt_index == psar_pkg::IDX_ID_HIGH)
         |=> mgmt_rdata == psar_pkg::ORG_ID_HIGH;
   endproperty
   a_id_high: assert property (p_id_high) else $error("id high wrong");
   property p_id_low;
      @(posedge clock) disable iff (!rst_n)
      rd_any && (mgmt_index == psar_pkg::IDX_ID_LOW)
         |=> mgmt_rdata == {psar_pkg::ORG_ID_LOW, psar_pkg::MODEL_NUM,
         psar_pkg::REVISION_NUM};
   endproperty
   a_id_low: assert property (p_id_low) else $error("id low wrong");
   // remote fault, pause and technology fields take exactly the value written
   property p_adv_rflt;
      @(posedge clock) disable iff (!rst_n)
      wr_adv |=> adv[psar_pkg::ADV_RFLT_BIT]
         == $past(mgmt_wdata[psar_pkg::ADV_RFLT_BIT]);
   endproperty
   a_adv_rflt: assert property (p_adv_rflt)
      else $error("adv remote fault not written");
   property p_adv_pause;
      @(posedge clock) disable iff (!rst_n)
      wr_adv |=> adv[psar_pkg::PAUSE_LSB +: 2]
         == $past(mgmt_wdata[psar_pkg::PAUSE_LSB +: 2]);
   endproperty
   a_adv_pause: assert property (p_adv_pause)
      else $error("adv pause not written");
   property p_adv_tech;
      @(posedge clock) disable iff (!rst_n)
      wr_adv |=> adv[psar_pkg::TECH_LSB +: 4]
         == $past(mgmt_wdata[psar_pkg::TECH_LSB +: 4]);
   endproperty
   a_adv_tech: assert property (p_adv_tech)
      else $error("adv technology not written");
   // stored words come back to their reset contents in any reset
   property p_word_reset;
      @(posedge clock)
      !rst_n ##1 !rst_n |-> (adv[4:0] == psar_pkg::SELECTOR_8023)
         && (adv[psar_pkg::TECH_LSB +: 4] == psar_pkg::ADV_TECH_RST)
         && (adv[15:9] == 7'h00) && (partner == 16'h0000);
   endproperty
   a_word_reset: assert property (p_word_reset)
      else $error("word not at reset value");
   property p_adv_res;
      @(posedge clock) disable iff (!rst_n)
      wr_adv |=> (adv[15:14] == 2'h0) && !adv[9] && !adv[12];
   endproperty
   a_adv_res: assert property (p_adv_res)
      else $error("reserved adv bits set");
   property p_pause_one;
      @(posedge clock) disable iff (!rst_n)
      !(pause_sym_en && pause_asym_en);
   endproperty
   a_pause_one: assert property (p_pause_one)
      else $error("both pause modes on");
   property p_partner_top;
      @(posedge clock) disable iff (!rst_n)
      partner_load |=> (partner[15:14] == 2'h0);
   endproperty
   a_partner_top: assert property (p_partner_top)
      else $error("np or ack set");
   // read-only partner fields follow the received code word
   property p_partner_fields;
      @(posedge clock) disable iff (!rst_n)
      partner_load |=> (partner[13] == $past(partner_word[13]))
         && (partner[11:5] == $past(partner_word[11:5]));
   endproperty
   a_partner_fields: assert property (p_partner_fields)
      else $error("partner fields not captured");
   property p_unmapped;
      @(posedge clock) disable iff (!rst_n)
      rd_any && ((mgmt_index == 5'h00)
         || (mgmt_index > psar_pkg::IDX_PARTNER)) |=> mgmt_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_ack;
      @(posedge clock) disable iff (!rst_n)
      mgmt_req |=> mgmt_ack;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_ack_single;
      @(posedge clock) disable iff (!rst_n)
      !mgmt_req |=> !mgmt_ack;
   endproperty
   a_ack_single: assert property (p_ack_single)
      else $error("ack without request");
   // after a status read the latches show only the live condition
   property p_release;
      @(posedge clock) disable iff (!rst_n)
      rd_status && !fault_s && !jab_s && link_s
         |=> (!fault_v || fault_s) && (!jab_v || jab_s)
         && (link_v || !link_s);
   endproperty
   a_release: assert property (p_release)
      else $error("latch not released by read");
   c_status_rd: cover property (@(posedge clock) rd_status && fault_v);
   c_adv_wr:    cover property (@(posedge clock) wr_adv);
   c_pause:     cover property (@(posedge clock) pause_asym_en);
   c_link_loss: cover property (@(posedge clock) rd_status && !link_v && link_s);
endmodule : psar_regs
`default_nettype wire

// ===== dv/psar_partner_model.sv
// line side and negotiation engine model facing the register bank
`timescale 1ns/10ps
`default_nettype none
module psar_partner_model (
   // clock
   input  wire logic        clock,
   // line levels and negotiation results
   output var  logic        link_up,
   output var  logic        remote_fault,
   output var  logic        jabber,
   output var  logic        neg_done,
   output var  logic        partner_load,
   output var  logic [15:0] partner_word
);
   // quiet line, nothing negotiated at time zero
   initial begin
      {link_up, remote_fault, jabber, neg_done, partner_load} = 5'h00;
      partner_word = 16'h0000;
   end
   // levels move only at a clock edge; the caller sits on one
   task automatic set_line(input logic lu, input logic rf, input logic jb);
      link_up      <= lu;
      remote_fault <= rf;
      jabber       <= jb;
   endtask : set_line
   // one code word; lines invert after so a stale hold is caught
   task automatic send(input logic [15:0] w);
      partner_word <= w;
      partner_load <= 1'b1;
      @(posedge clock);
      partner_load <= 1'b0;
      partner_word <= ~w;
   endtask : send
   // negotiation finished or restarted
   task automatic done(input logic d);
      neg_done <= d;
   endtask : done
endmodule : psar_partner_model
`default_nettype wire

// ===== dv/phy_status_autoneg_regs_tb.sv
// self-checking bench for the phy status and negotiation register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
   begin \
      checked++; \
      if ((got) !== (ex)) begin \
         err_count++; \
         $display("wrong value %s expected %h seen %h", nm, ex, got); \
      end \
   end
module phy_status_autoneg_regs_tb;
   // -------------------------------------------------------------
   // signals
   // -------------------------------------------------------------
   logic        clock, rst_n, mgmt_req, mgmt_write, mgmt_ack;
   logic [4:0]  mgmt_index;
   logic [15:0] mgmt_wdata, mgmt_rdata, partner_word, rd, w;
   logic        link_up, remote_fault, jabber, neg_done, partner_load;
   logic        pause_sym_en, pause_asym_en;
   logic [1:0]  pause_seen;
   int          err_count, checked, seed;
   localparam logic [15:0] ID_LOW = {psar_pkg::ORG_ID_LOW,
      psar_pkg::MODEL_NUM, psar_pkg::REVISION_NUM};
   assign pause_seen = {pause_sym_en, pause_asym_en};
   // 250 MHz clock
   initial clock = 1'b0;
   always #2 clock = ~clock;
   psar_regs psar_regs_i (.clock(clock), .rst_n(rst_n),
      .mgmt_req(mgmt_req), .mgmt_write(mgmt_write),
      .mgmt_index(mgmt_index), .mgmt_wdata(mgmt_wdata),
      .mgmt_rdata(mgmt_rdata), .mgmt_ack(mgmt_ack), .link_up(link_up),
      .remote_fault(remote_fault), .jabber(jabber), .neg_done(neg_done),
      .partner_load(partner_load), .partner_word(partner_word),
      .pause_sym_en(pause_sym_en), .pause_asym_en(pause_asym_en));
   psar_partner_model psar_partner_model_i (.clock(clock),
      .link_up(link_up), .remote_fault(remote_fault), .jabber(jabber),
      .neg_done(neg_done), .partner_load(partner_load),
      .partner_word(partner_word));
   // -------------------------------------------------------------
   // expectations and bus tasks
   // -------------------------------------------------------------
   // flags in order done, remote fault, link, jabber
   function automatic logic [15:0] st(input logic [3:0] f);
      return {5'b01111, 5'b00000, f[3], f[2], 1'b1, f[1], f[0], 1'b1};
   endfunction : st
   // symmetric wins, so a both-kinds offer never enables two modes
   function automatic logic [1:0] pz(input logic [1:0] a, input logic [1:0] p);
      logic s;
      s = a[0] & p[0];
      return {s, ~s & a[1] & p[1]};
   endfunction : pz
   task automatic tally_and_finish();
      if (err_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish
   // one pulse request by index; answer sampled a cycle later
   task automatic acc(input logic wr, input logic [4:0] idx,
                      input logic [15:0] wd);
      int n;
      mgmt_req   <= 1'b1;
      mgmt_write <= wr;
      mgmt_index <= idx;
      mgmt_wdata <= wd;
      @(posedge clock);
      mgmt_req <= 1'b0;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (mgmt_ack !== 1'b1 && n < 4);
      rd = mgmt_rdata;
      `CHK("ack delay", 1, n)
      if (mgmt_ack !== 1'b1) begin
         err_count++;
         tally_and_finish();
      end
   endtask : acc
   task automatic rchk(input logic [4:0] idx, input logic [15:0] ex,
                       input string nm);
      acc(1'b0, idx, 16'h0000);
      `CHK(nm, ex, rd)
   endtask : rchk
   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      seed = 87843;
      err_count = 0;
      checked = 0;
      {rst_n, mgmt_req, mgmt_write} = 3'h0;
      mgmt_index = 5'h00;
      mgmt_wdata = 16'h0000;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      // reset view, unmapped indexes and read-only words
      rchk(5'h01, st(4'h0), "status");
      rchk(5'h02, psar_pkg::ORG_ID_HIGH, "id high");
      rchk(5'h03, ID_LOW, "id low");
      rchk(5'h04, 16'h01E1, "adv reset");
      rchk(5'h05, 16'h0000, "partner reset");
      rchk(5'h00, 16'h0000, "unmapped");
      rchk(5'h1F, 16'h0000, "unmapped");
      acc(1'b1, 5'h01, 16'hFFFF);
      acc(1'b1, 5'h03, 16'h0000);
      acc(1'b1, 5'h05, 16'hFFFF);
      rchk(5'h01, st(4'h0), "status ro");
      rchk(5'h03, ID_LOW, "id ro");
      rchk(5'h05, 16'h0000, "partner ro");
      // writable advertisement fields, all-ones corner first
      for (int i = 0; i < 10; i++) begin
         w = (i == 0) ? 16'hFFFF : 16'($random(seed));
         acc(1'b1, 5'h04, w);
         rchk(5'h04, w & 16'h2DFF, "advertise");
      end
      // mid-run reset brings the writable fields back to reset values
      rst_n <= 1'b0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rchk(5'h04, 16'h01E1, "adv after reset");
      rchk(5'h01, st(4'h0), "status after reset");
      // short link drop and fault pulses must survive until read
      psar_partner_model_i.set_line(1'b1, 1'b0, 1'b0);
      repeat (4) @(posedge clock);
      acc(1'b0, 5'h01, 16'h0000);
      rchk(5'h01, st(4'h2), "link up");
      psar_partner_model_i.set_line(1'b0, 1'b1, 1'b1);
      repeat (3) @(posedge clock);
      psar_partner_model_i.set_line(1'b1, 1'b0, 1'b0);
      repeat (4) @(posedge clock);
      rchk(5'h01, st(4'h5), "latched");
      rchk(5'h01, st(4'h2), "released");
      // every pause pairing against random partner words
      for (int i = 0; i < 16; i++) begin
         w = (i == 0) ? 16'hFFFF : 16'($random(seed));
         w[11:10] = i[1:0];
         acc(1'b1, 5'h04, {4'h0, i[3:2], 10'h1E1});
         psar_partner_model_i.send(w);
         rchk(5'h05, w & 16'h2FFF, "partner");
         psar_partner_model_i.done(1'b1);
         repeat (3) @(posedge clock);
         `CHK("pause", pz(i[3:2], i[1:0]), pause_seen)
         rchk(5'h01, st(4'hA), "done");
         psar_partner_model_i.done(1'b0);
      end
      rchk(5'h01, st(4'h2), "not done");
      tally_and_finish();
   end
endmodule : phy_status_autoneg_regs_tb
`default_nettype wire
